// ===== design/eisf_pkg.sv
// Shared constants and types of the two-wire EEPROM slave front end.
// Assumes a single 40 MHz system clock and bus lines already synchronous to it.
package eisf_pkg;

    // ------------------------------------------------------------
    // Clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ        = 40_000_000;
    localparam int unsigned WRITE_TIME_MS = 10;
    // Longest time: rounds down to whole cycles
    localparam int unsigned WRITE_CYCLES  = (CLK_HZ / 1000) * WRITE_TIME_MS;

    // ------------------------------------------------------------
    // Select byte layout
    // ------------------------------------------------------------
    localparam int unsigned BYTE_BITS     = 8;
    localparam logic [3:0]  BIT_CNT_FULL  = 4'h8;
    localparam logic [3:0]  BIT_CNT_RST   = 4'h0;
    localparam int unsigned TYPE_MSB      = 7;
    localparam int unsigned TYPE_LSB      = 4;
    localparam int unsigned RW_POS        = 0;
    localparam logic        RW_READ       = 1'b1;
    // Arbitrary neutral device-type value, override per product
    localparam logic [3:0]  DEV_TYPE_DFLT = 4'h6;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  SHIFT_RST     = 8'h00;
    localparam logic        SDA_DRIVE_LVL = 1'b0;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_SELECT,
        ST_ACK,
        ST_RXBYTE,
        ST_READ,
        ST_IGNORE,
        ST_WRITING
    } eisf_state_t;

endpackage

// ===== design/eisf_line_sampler.sv
// Bus line sampler: edge and START/STOP pulses from the serial lines.
// Assumes scl and sda inputs are already synchronous to clk_sys.
`timescale 1ns/1ps
module eisf_line_sampler
    import eisf_pkg::*;
(
    input  wire logic clk_sys,   // system clock
    input  wire logic rst_n,     // synchronous reset, active low
    input  wire logic sclIn,     // serial clock line level
    input  wire logic sdaIn,     // serial data line level
    output logic      sclRise,   // one-cycle pulse, clock rose
    output logic      sclFall,   // one-cycle pulse, clock fell
    output logic      startSeen, // one-cycle pulse, START detected
    output logic      stopSeen,  // one-cycle pulse, STOP detected
    output logic      sdaNow     // data level aligned with the pulses
);

    // ------------------------------------------------------------
    // Previous samples and decode
    // ------------------------------------------------------------
    logic sclPrev_q;
    logic sdaPrev_q;
    wire  riseD  = sclIn & ~sclPrev_q;
    wire  fallD  = ~sclIn & sclPrev_q;
    // Data edges count only while the clock stays high on both samples
    wire  startD = sclIn & sclPrev_q & sdaPrev_q & ~sdaIn;
    wire  stopD  = sclIn & sclPrev_q & ~sdaPrev_q & sdaIn;

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
            sclRise   <= 1'b0;
            sclFall   <= 1'b0;
            startSeen <= 1'b0;
            stopSeen  <= 1'b0;
            sdaNow    <= 1'b1;
        end else begin
            sclPrev_q <= sclIn;
            sdaPrev_q <= sdaIn;
            sclRise   <= riseD;
            sclFall   <= fallD;
            startSeen <= startD;
            stopSeen  <= stopD;
            sdaNow    <= sdaIn;
        end
    end

endmodule

// ===== design/eisf_slave_front_end.sv
// Two-wire serial slave front end of a small serial EEPROM.
// Assumes bus lines synchronous to clk_sys; the master drives the serial clock.
//
// Behaviour
// - Device is slave only; master clocks everything
// - START: data falls while clock high
// - Silent on bus until START seen
// - STOP: data rises while clock high, ends communication
// - STOP after read returns to standby
// - STOP after write launches timed write cycle
// - Transmitter releases; receiver acks in ninth pulse
// - Data sampled on each rising clock edge
// - Top four select bits match device type
// - Three following select bits are don't care
// - Eighth bit: one read, zero write
// - Matching select byte acked in ninth bit
// - Write cycle ignores all requests, no ack
// - Writes execute only while write enable high
// - First falling clock edge enters bidirectional mode, sticky
`timescale 1ns/1ps
module eisf_slave_front_end
    import eisf_pkg::*;
#(
    parameter int unsigned WRITE_CYC = WRITE_CYCLES,  // write cycle length in clocks
    parameter logic [3:0]  DEV_TYPE  = DEV_TYPE_DFLT  // device type identifier
) (
    input  wire logic clk_sys,                          // system clock, 40 MHz
    input  wire logic rst_n,                            // synchronous reset, active low
    input  wire logic sclIn,                            // serial clock line level
    input  wire logic sdaIn,                            // serial data line level
    input  wire logic transmit_only_clock_write_enable, // write enable, active high
    output logic      sdaOut,                           // data pin drive value
    output logic      sdaOe_n,                          // data pin enable, low drives
    output logic      bidirMode,                        // bidirectional mode entered
    output logic      writeBusy,                        // internal write cycle running
    output logic      addressed,                        // select byte matched and acked
    output logic      readSelected                      // addressed for a read
);

    localparam int unsigned CW = $clog2(WRITE_CYC + 1);
    localparam logic [CW-1:0] CNT_LOAD = CW'(WRITE_CYC);
    localparam logic [CW-1:0] CNT_ONE  = CW'(1);
    localparam logic [CW-1:0] CNT_ZERO = CW'(0);

    // ------------------------------------------------------------
    // Line sampling
    // ------------------------------------------------------------
    logic sclRise;
    logic sclFall;
    logic startSeen;
    logic stopSeen;
    logic sdaNow;

    eisf_line_sampler u_sampler (
        .clk_sys   (clk_sys),
        .rst_n     (rst_n),
        .sclIn     (sclIn),
        .sdaIn     (sdaIn),
        .sclRise   (sclRise),
        .sclFall   (sclFall),
        .startSeen (startSeen),
        .stopSeen  (stopSeen),
        .sdaNow    (sdaNow)
    );

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    eisf_state_t   state_q;
    eisf_state_t   state_d;
    logic [3:0]    bitCnt_q;
    logic [3:0]    bitCnt_d;
    logic [7:0]    shift_q;
    logic [7:0]    shift_d;
    logic          rw_q;
    logic          rw_d;
    logic          oeN_d;
    logic          addr_d;
    logic [CW-1:0] writeCnt_q;
    logic [CW-1:0] writeCnt_d;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Only the type field is compared; the three bits after it are ignored
    wire typeMatch  = (shift_q[TYPE_MSB:TYPE_LSB] == DEV_TYPE);
    wire byteDone   = (bitCnt_q == BIT_CNT_FULL);
    wire receiving  = (state_q == ST_SELECT) || (state_q == ST_RXBYTE);
    wire writeCmd   = addressed && (rw_q != RW_READ);
    wire inFrame    = (state_q != ST_IDLE) && (state_q != ST_IGNORE);
    // Write enable is checked when STOP arrives; low means nothing is programmed
    wire launchWr   = stopSeen && writeCmd && inFrame
                      && transmit_only_clock_write_enable;
    wire wrDoneNow  = (writeCnt_q == CNT_ONE);
    // Bus is not listened to before the mode switch or during the write cycle
    wire listening  = bidirMode && (state_q != ST_WRITING);

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        state_d    = state_q;
        bitCnt_d   = bitCnt_q;
        shift_d    = shift_q;
        rw_d       = rw_q;
        oeN_d      = sdaOe_n;
        addr_d     = addressed;
        writeCnt_d = writeCnt_q;
        if (state_q == ST_WRITING) begin
            writeCnt_d = writeCnt_q - CNT_ONE;
            if (wrDoneNow) begin
                state_d = ST_IDLE;
            end
        end else if (!listening) begin
            oeN_d = 1'b1;
        end else if (startSeen) begin
            // A repeated START restarts select decoding from any state except ST_WRITING
            state_d  = ST_SELECT;
            bitCnt_d = BIT_CNT_RST;
            oeN_d    = 1'b1;
            addr_d   = 1'b0;
        end else if (stopSeen) begin
            oeN_d  = 1'b1;
            addr_d = 1'b0;
            if (launchWr) begin
                state_d    = ST_WRITING;
                writeCnt_d = CNT_LOAD;
            end else begin
                state_d = ST_IDLE;
            end
        end else begin
            unique case (state_q)
                ST_SELECT, ST_RXBYTE: begin
                    if (sclRise && !byteDone) begin
                        shift_d  = {shift_q[BYTE_BITS-2:0], sdaNow};
                        bitCnt_d = bitCnt_q + 4'h1;
                    end else if (sclFall && byteDone) begin
                        if ((state_q == ST_SELECT) && !typeMatch) begin
                            state_d = ST_IGNORE;
                        end else begin
                            state_d = ST_ACK;
                            oeN_d   = 1'b0;
                            if (state_q == ST_SELECT) begin
                                rw_d   = shift_q[RW_POS];
                                addr_d = 1'b1;
                            end
                        end
                    end
                end
                ST_ACK: begin
                    if (sclFall) begin
                        // Release at the end of the ninth pulse
                        oeN_d    = 1'b1;
                        bitCnt_d = BIT_CNT_RST;
                        state_d  = (rw_q == RW_READ) ? ST_READ : ST_RXBYTE;
                    end
                end
                ST_IDLE, ST_READ, ST_IGNORE, ST_WRITING: begin
                    oeN_d = 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            state_q    <= ST_IDLE;
            bitCnt_q   <= BIT_CNT_RST;
            shift_q    <= SHIFT_RST;
            rw_q       <= 1'b0;
            writeCnt_q <= CNT_ZERO;
        end else begin
            state_q    <= state_d;
            bitCnt_q   <= bitCnt_d;
            shift_q    <= shift_d;
            rw_q       <= rw_d;
            writeCnt_q <= writeCnt_d;
        end
    end

    // Only ever pulls low; the line is never driven high, as a slave must not
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            sdaOut       <= SDA_DRIVE_LVL;
            sdaOe_n      <= 1'b1;
            bidirMode    <= 1'b0;
            writeBusy    <= 1'b0;
            addressed    <= 1'b0;
            readSelected <= 1'b0;
        end else begin
            sdaOut       <= SDA_DRIVE_LVL;
            sdaOe_n      <= oeN_d;
            bidirMode    <= bidirMode | sclFall;
            writeBusy    <= (state_d == ST_WRITING);
            addressed    <= addr_d;
            readSelected <= addr_d && (rw_d == RW_READ);
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_SILENT_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_IDLE) |-> sdaOe_n)
        else $error("data line driven while idle");

    AST_START_ENTRY: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (startSeen && listening) |=> (state_q == ST_SELECT) && (bitCnt_q == 4'h0))
        else $error("START did not open select decoding");

    AST_SAMPLE_RISE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sclRise && receiving && !byteDone && listening && !startSeen && !stopSeen)
        |=> (shift_q[0] == $past(sdaNow)) && (bitCnt_q == $past(bitCnt_q) + 4'h1))
        else $error("data bit not sampled on clock rise");

    AST_ACK_SELECT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_SELECT && byteDone && sclFall && typeMatch
         && listening && !startSeen && !stopSeen)
        |=> !sdaOe_n && addressed && (state_q == ST_ACK))
        else $error("matching select byte not acknowledged");

    AST_ACK_RELEASE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_ACK && sclFall && !startSeen && !stopSeen)
        |=> sdaOe_n ##1 sdaOe_n)
        else $error("acknowledge held past ninth pulse");

    AST_NO_ACK_MISMATCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_SELECT && byteDone && sclFall && !typeMatch
         && listening && !startSeen && !stopSeen)
        |=> (state_q == ST_IGNORE) && sdaOe_n && !addressed)
        else $error("mismatched select byte was answered");

    AST_BUSY_SILENT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_WRITING) |-> sdaOe_n && writeBusy && (writeCnt_q <= CNT_LOAD))
        else $error("bus answered during write cycle");

    AST_STOP_READ: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (stopSeen && listening && !startSeen && state_q == ST_READ)
        |=> (state_q == ST_IDLE) && !writeBusy)
        else $error("STOP after read did not reach standby");

    AST_WRITE_LAUNCH: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (stopSeen && listening && !startSeen && state_q == ST_RXBYTE
         && transmit_only_clock_write_enable)
        |=> (state_q == ST_WRITING) && (writeCnt_q == CNT_LOAD) && writeBusy)
        else $error("STOP after write did not start write cycle");

    AST_WRITE_INHIBIT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (stopSeen && listening && !startSeen && state_q == ST_RXBYTE
         && !transmit_only_clock_write_enable)
        |=> (state_q == ST_IDLE) && !writeBusy)
        else $error("write executed with write enable low");

    AST_MODE_STICKY: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (sclFall || bidirMode) |=> bidirMode)
        else $error("bidirectional mode lost or not entered");

    AST_RW_CAPTURE: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_ACK && $past(state_q) == ST_SELECT)
        |-> (readSelected == $past(shift_q[0])))
        else $error("direction bit not captured");

    AST_DRIVE_LOW: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !sdaOe_n |-> (sdaOut == SDA_DRIVE_LVL))
        else $error("data line driven high");

    AST_STOP_ENDS: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (stopSeen && listening && !startSeen) |=> !addressed && sdaOe_n)
        else $error("STOP did not end communication");

    AST_IGNORE_SILENT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_IGNORE) |-> sdaOe_n && !addressed)
        else $error("unaddressed device answered");

    AST_WRITE_END: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_WRITING && wrDoneNow) |=> (state_q == ST_IDLE) && !writeBusy)
        else $error("write cycle did not end on time");

    AST_BUSY_DEAF: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_WRITING && startSeen) |=> (state_q != ST_SELECT) && sdaOe_n)
        else $error("START accepted during write cycle");

    AST_PRE_MODE_DEAF: assert property (@(posedge clk_sys) disable iff (!rst_n)
        !bidirMode |-> (state_q == ST_IDLE) && sdaOe_n)
        else $error("bus answered before mode switch");

    AST_RX_COUNT: assert property (@(posedge clk_sys) disable iff (!rst_n)
        receiving |-> (bitCnt_q <= BIT_CNT_FULL))
        else $error("received bit count overran");

    AST_DATA_ACK: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_RXBYTE && byteDone && sclFall && listening
         && !startSeen && !stopSeen)
        |=> !sdaOe_n && (state_q == ST_ACK))
        else $error("received data byte not acknowledged");

    AST_ACK_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_n)
        (state_q == ST_ACK && !sclFall && !startSeen && !stopSeen) |=> !sdaOe_n)
        else $error("acknowledge dropped inside ninth bit");

endmodule

// ===== sim/eisf_bus_master.sv
// Behavioural two-wire bus master that drives the front end's serial lines.
// Assumes the bench resolves the data line with a pull-up and feeds it back in.
`timescale 1ns/1ps
module eisf_bus_master (
    input  wire logic clk_sys, // system clock
    input  wire logic sdaLine, // resolved data line level
    output logic      scl,     // serial clock level, master only
    output logic      sdaDrv   // data drive, 0 pulls low, 1 releases
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    int hp    = 4; // Half period in clocks; bench switches prompt and slow
    bit clash = 0; // Line seen low while the master had released it

    initial begin
        scl    = 1'b1;
        sdaDrv = 1'b1;
    end

    // ------------------------------------------------------------
    // Bus conditions
    // ------------------------------------------------------------
    task automatic waitc(input int n);
        repeat (n) @(posedge clk_sys);
    endtask

    task automatic startCond();
        waitc(1);
        sdaDrv <= 1'b1;
        waitc(hp);
        scl <= 1'b1;
        waitc(hp);
        sdaDrv <= 1'b0;
        waitc(hp);
        scl <= 1'b0;
    endtask

    task automatic stopCond();
        waitc(1);
        sdaDrv <= 1'b0;
        waitc(hp);
        scl <= 1'b1;
        waitc(hp);
        sdaDrv <= 1'b1;
        waitc(hp);
    endtask

    // One clock pulse; data moves one edge after scl falls, never while high
    task automatic bitSlot(input logic b, output logic seen);
        waitc(1);
        sdaDrv <= b;
        waitc(hp);
        scl <= 1'b1;
        waitc(hp);
        seen = sdaLine;
        scl <= 1'b0;
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic seen;
        for (int i = 7; i >= 0; i--) begin
            bitSlot(b[i], seen);
            if (b[i] && !seen)
                clash = 1;
        end
        bitSlot(1'b1, seen);
        ack = !seen;
        waitc(hp);
    endtask
endmodule

// ===== sim/testbench.sv
// Self-checking bench for the EEPROM slave front end with a modelled bus master.
// Assumes the write cycle is shortened through the WRITE_CYC parameter.
`timescale 1ns/1ps
module testbench;
    import eisf_pkg::*;

    localparam int unsigned WCYC = 300;
    localparam logic [3:0]  DEVT = 4'h9; // Arbitrary type value

    logic        clk_sys = 1'b0;
    logic        rst_n   = 1'b0;
    logic        wrEn    = 1'b0;
    logic        scl;
    logic        sdaDrv;
    logic        sdaOut;
    logic        sdaOe_n;
    logic        bidirMode;
    logic        writeBusy;
    logic        addressed;
    logic        readSelected;
    int          fails     = 0;
    int          tests_run = 0;
    int          busyRun   = 0;
    int          lastRun   = 0;
    wire logic   sdaLine   = sdaDrv & (sdaOe_n ? 1'b1 : sdaOut);

    eisf_bus_master u_eisf_bus_master (
        .clk_sys (clk_sys),
        .sdaLine (sdaLine),
        .scl     (scl),
        .sdaDrv  (sdaDrv)
    );

    eisf_slave_front_end #(.WRITE_CYC(WCYC), .DEV_TYPE(DEVT)) u_eisf_slave_front_end (
        .clk_sys                          (clk_sys),
        .rst_n                            (rst_n),
        .sclIn                            (scl),
        .sdaIn                            (sdaLine),
        .transmit_only_clock_write_enable (wrEn),
        .sdaOut                           (sdaOut),
        .sdaOe_n                          (sdaOe_n),
        .bidirMode                        (bidirMode),
        .writeBusy                        (writeBusy),
        .addressed                        (addressed),
        .readSelected                     (readSelected)
    );

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Length of the last write-busy stretch
    always @(posedge clk_sys) begin
        if (writeBusy === 1'b1)
            busyRun <= busyRun + 1;
        else if (busyRun != 0) begin
            lastRun <= busyRun;
            busyRun <= 0;
        end
    end

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task automatic end_sim();
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Expected address match: only the type field counts
    function automatic logic selHit(input logic [7:0] sel);
        return (sel[7:4] == DEVT);
    endfunction

    task automatic xfer(input logic [7:0] sel, input logic [7:0] dat, input logic en);
        logic ack;
        logic hit;
        int   n;
        hit = selHit(sel);
        @(posedge clk_sys);
        wrEn <= en;
        u_eisf_bus_master.startCond();
        u_eisf_bus_master.sendByte(sel, ack);
        #1;
        check(ack, hit);
        check(addressed, hit);
        check(readSelected, hit & sel[0]);
        check(sdaOe_n, 1'b1);
        if (!sel[0] || !hit) begin
            u_eisf_bus_master.sendByte(dat, ack);
            check(ack, hit);
        end
        u_eisf_bus_master.stopCond();
        repeat (3) @(posedge clk_sys);
        #1;
        check(addressed, 1'b0);
        check(writeBusy, hit & !sel[0] & en);
        if (writeBusy === 1'b1) begin
            // Polling during the write cycle must go unanswered
            u_eisf_bus_master.startCond();
            u_eisf_bus_master.sendByte({DEVT, 4'h0}, ack);
            check(ack, 1'b0);
            u_eisf_bus_master.stopCond();
            for (n = 0; n < 2 * WCYC && writeBusy === 1'b1; n++)
                @(posedge clk_sys);
            if (n >= 2 * WCYC) begin
                fails++;
                end_sim();
            end
            repeat (2) @(posedge clk_sys);
            #1;
            check(lastRun >= WCYC - 1 && lastRun <= WCYC + 1, 1'b1);
        end
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        logic       ack;
        logic [7:0] sel;
        void'($urandom(94326));
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        #1;
        check({sdaOe_n, bidirMode, writeBusy, addressed, readSelected}, 8'h10);
        // Before the first scl fall the START is not seen: no answer
        u_eisf_bus_master.startCond();
        u_eisf_bus_master.sendByte({DEVT, 4'h0}, ack);
        #1;
        check(ack, 1'b0);
        check(bidirMode, 1'b1);
        u_eisf_bus_master.stopCond();
        xfer({DEVT, 4'he}, 8'h00, 1'b1);
        xfer({DEVT ^ 4'h8, 4'h0}, 8'hff, 1'b1);
        xfer({DEVT, 4'h1}, 8'h00, 1'b1);
        for (int k = 0; k < 14; k++) begin
            u_eisf_bus_master.hp = (k % 3 == 0) ? 7 : 3;
            sel = 8'($urandom);
            if (k % 2 == 0)
                sel[7:4] = DEVT;
            xfer(sel, 8'($urandom), 1'($urandom));
        end
        // Repeated START switches direction without a STOP
        u_eisf_bus_master.startCond();
        u_eisf_bus_master.sendByte({DEVT, 4'hb}, ack);
        #1;
        check(readSelected, 1'b1);
        u_eisf_bus_master.startCond();
        u_eisf_bus_master.sendByte({DEVT, 4'h4}, ack);
        #1;
        check(ack, 1'b1);
        check(readSelected, 1'b0);
        @(posedge clk_sys);
        wrEn <= 1'b0;
        u_eisf_bus_master.stopCond();
        repeat (3) @(posedge clk_sys);
        #1;
        check(writeBusy, 1'b0);
        check(bidirMode, 1'b1);
        check(u_eisf_bus_master.clash, 1'b0);
        check(sdaOut, 1'b0);
        end_sim();
    end

    initial begin
        repeat (100000) @(posedge clk_sys);
        fails++;
        end_sim();
    end
endmodule
